// file: verilog/hvsp_regs.sv
`timescale 1ns/1ps
module hvsp_regs
   import hvsp_pkg::*;
#(
   parameter int unsigned LOSS_CYC = LOSS_CYC_DEF,
   parameter int unsigned H_PRES_CYC = H_PRES_CYC_DEF,
   parameter int unsigned V_PRES_CYC = V_PRES_CYC_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire hvsp_bus_t bus,
   input wire logic hsync_in,
   input wire logic vsync_in,
   output logic [7:0] rdata_q,
   output logic core_external_irq_1_n_q,
   output logic hblank_q,
   output logic vblank_q,
   output logic clamp_q,
   output logic extracted_composite_vert_q
);
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction

   hvsp_sync_t h_st, v_st, cv_st, vsel;
   logic [7:0] ctrl0_q, clamp_ctl_q, flags_q, en_q;
   logic [9:0] hact_len_q;
   logic [15:0] phase_q, hper_q;
   logic [7:0] line_div_q;
   logic [9:0] frame_div_q;
   logic [5:0] lines_q;
   logic [LINE_W-1:0] line_pub_q;
   logic [4:0] prev_q;
   logic l_ovf_prev_q;
   hvsp_clamp_t cl_state_q;
   logic [6:0] cl_cnt_q;

   // Composite vertical pulse: line sync held active beyond the minimum
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hact_len_q <= '0;
         extracted_composite_vert_q <= 1'b0;
      end else begin
         hact_len_q <= !h_st.active ? '0 :
                       (hact_len_q < 10'(CV_MIN_CYC) ? hact_len_q + 1'b1 : hact_len_q);
         extracted_composite_vert_q <= h_st.active && hact_len_q >= 10'(CV_MIN_CYC); // RULE2
      end
   end

   hvsp_sync_mon #(.PRES_CYC(H_PRES_CYC), .LOSS_CYC(LOSS_CYC)) u_line_mon (
      .clk(clk),
      .sys_rst(sys_rst),
      .sync_in(hsync_in),
      .status(h_st)
   );
   hvsp_sync_mon #(.PRES_CYC(V_PRES_CYC), .LOSS_CYC(LOSS_CYC)) u_frame_mon (
      .clk(clk),
      .sys_rst(sys_rst),
      .sync_in(vsync_in),
      .status(v_st)
   );
   hvsp_sync_mon #(.PRES_CYC(V_PRES_CYC), .LOSS_CYC(LOSS_CYC)) u_comp_mon (
      .clk(clk),
      .sys_rst(sys_rst),
      .sync_in(extracted_composite_vert_q),
      .status(cv_st)
   );

   // Vertical source selection
   wire [1:0] sel = ctrl0_q[C0_SEL_HI:C0_SEL_LO];
   wire comp_en = sel != SEL_OFF; // RULE9
   wire use_cv = (sel == SEL_COMPOSITE) ||
                 (sel == SEL_AUTO && cv_st.present && !v_st.present); // RULE9 RULE10
   assign vsel = use_cv ? cv_st : v_st; // RULE4

   // Register bus decode
   wire wr_ctrl0 = bus.wr && hit(bus.addr, ADDR_CTRL0); // RULE20
   wire wr_clamp = bus.wr && hit(bus.addr, ADDR_CLAMP);
   wire wr_flags = bus.wr && hit(bus.addr, ADDR_FLAGS);
   wire wr_en = bus.wr && hit(bus.addr, ADDR_ENABLES);

   // Measurement time bases
   wire line_tick = line_div_q == 8'(LINE_TICK_CYC - 1);
   wire frame_tick = frame_div_q == 10'(FRAME_TICK_CYC - 1);
   wire line_mark = h_st.lead && lines_q == LINE_AVG_LAST;
   logic [LINE_W-1:0] l_val;
   logic l_ovf, l_done;
   logic [FRAME_W-1:0] f_val;
   logic f_ovf, f_chg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         line_div_q <= '0;
         frame_div_q <= '0;
         lines_q <= '0;
      end else begin
         line_div_q <= line_tick ? '0 : line_div_q + 1'b1;
         frame_div_q <= frame_tick ? '0 : frame_div_q + 1'b1;
         if (h_st.lead) lines_q <= lines_q + 1'b1; // RULE22
      end
   end

   hvsp_period_ctr #(.W(LINE_W), .BIAS(1'b1)) u_line_ctr (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(line_tick),
      .mark(line_mark),
      .value_q(l_val),
      .ovf_q(l_ovf),
      .done_q(l_done),
      .chg_q()
   );
   hvsp_period_ctr #(.W(FRAME_W), .BIAS(1'b0)) u_frame_ctr (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(frame_tick),
      .mark(vsel.lead), // RULE23
      .value_q(f_val),
      .ovf_q(f_ovf),
      .done_q(),
      .chg_q(f_chg)
   );

   // Line count shown once per frame while frames run, else on every result
   wire line_pub = (l_done && !vsel.present) || (vsel.lead && vsel.present); // RULE22
   wire line_ev = (line_pub && l_val != line_pub_q) || (l_ovf && !l_ovf_prev_q); // RULE24

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         line_pub_q <= '0;
         l_ovf_prev_q <= 1'b0;
      end else begin
         if (line_pub) line_pub_q <= l_val;
         l_ovf_prev_q <= l_ovf;
      end
   end

   // Sync events into sticky flags
   wire [7:0] set_w = {
      h_st.present != prev_q[4],
      (v_st.present != prev_q[3]) || (comp_en && cv_st.present != prev_q[2]),
      h_st.polarity != prev_q[1],
      vsel.polarity != prev_q[0],
      line_ev,
      f_chg,
      1'b0,
      vsel.lead
   }; // RULE21
   wire [7:0] clr_w = wr_flags ? ~bus.wdata : 8'h00;
   wire [7:0] flags_d = ((flags_q & ~clr_w) | set_w) & FLAG_MASK; // RULE18

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl0_q <= REG_RESET; // RULE25
         clamp_ctl_q <= REG_RESET;
         flags_q <= REG_RESET;
         en_q <= REG_RESET;
         prev_q <= '0;
         core_external_irq_1_n_q <= 1'b1;
      end else begin
         if (wr_ctrl0) ctrl0_q <= bus.wdata; // RULE20
         if (wr_clamp) clamp_ctl_q <= bus.wdata;
         if (wr_en) en_q <= bus.wdata & FLAG_MASK;
         flags_q <= flags_d; // RULE17
         prev_q <= {h_st.present, v_st.present, cv_st.present, h_st.polarity, vsel.polarity};
         core_external_irq_1_n_q <= ~|(flags_q & en_q); // RULE17
      end
   end

   // Read path, data only in the cycle after the strobe
   wire [7:0] status_w = {cv_st.present, 1'b0, h_st.polarity, vsel.polarity,
                          h_st.present, v_st.present, h_st.idle, v_st.idle}; // RULE1 RULE26
   wire [7:0] rd_mux =
      hit(bus.addr, ADDR_STATUS) ? status_w :
      hit(bus.addr, ADDR_LINE_HI) ? {l_ovf, 1'b0, line_pub_q[13:8]} : // RULE7
      hit(bus.addr, ADDR_LINE_LO) ? line_pub_q[7:0] :
      hit(bus.addr, ADDR_FRAME_HI) ? {f_ovf, 3'h0, f_val[11:8]} : // RULE8
      hit(bus.addr, ADDR_FRAME_LO) ? f_val[7:0] :
      hit(bus.addr, ADDR_FLAGS) ? flags_q : 8'h00; // RULE26

   always_ff @(posedge clk) begin
      if (sys_rst) rdata_q <= 8'h00;
      else rdata_q <= bus.rd ? rd_mux : 8'h00;
   end

   // Blanking outputs with pulse insertion during composite vertical time
   wire cv_time = use_cv && extracted_composite_vert_q;
   wire ins_pulse = phase_q < {3'h0, hper_q[15:3]};
   wire hblank_raw = cv_time ? (!ctrl0_q[C0_NOINS] && ins_pulse) : h_st.active; // RULE11

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_q <= '0;
         hper_q <= '0;
         hblank_q <= 1'b0;
         vblank_q <= 1'b0;
      end else begin
         if (h_st.lead && !extracted_composite_vert_q) begin
            phase_q <= '0;
            hper_q <= phase_q;
         end else if (cv_time && phase_q >= hper_q) phase_q <= '0;
         else if (!(&phase_q)) phase_q <= phase_q + 1'b1;
         hblank_q <= hblank_raw ^ ctrl0_q[C0_HBLANK_POLARITY]; // RULE12
         vblank_q <= vsel.active ^ ctrl0_q[C0_VBLANK_POLARITY]; // RULE13
      end
   end

   // Clamp pulse generator
   wire clamp_start = clamp_ctl_q[CL_EDGE] ? h_st.lead : h_st.trail; // RULE14
   wire [6:0] clamp_len = 7'(({1'b0, clamp_ctl_q[CL_W_HI:CL_W_LO]} + 4'h1) * CLAMP_STEP_CYC);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cl_state_q <= CL_IDLE;
         cl_cnt_q <= '0;
         clamp_q <= 1'b0;
      end else begin
         case (cl_state_q)
            CL_IDLE: begin
               if (clamp_start) begin
                  cl_state_q <= CL_RUN;
                  cl_cnt_q <= clamp_len; // RULE16
               end
            end
            CL_RUN: begin
               if (cl_cnt_q == 7'h01) cl_state_q <= CL_IDLE;
               cl_cnt_q <= cl_cnt_q - 1'b1;
            end
            default: cl_state_q <= CL_IDLE;
         endcase
         clamp_q <= (cl_state_q == CL_RUN) ~^ clamp_ctl_q[CL_POL]; // RULE15
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence clamp_begin_s;
      cl_state_q == CL_IDLE && clamp_start;
   endsequence
   sequence clamp_end_s;
      cl_state_q == CL_RUN && cl_cnt_q == 7'h01;
   endsequence

   irq_drive_a: assert property ( // RULE17
      (|(flags_q & en_q)) |=> !core_external_irq_1_n_q)
      else $error("interrupt not driven low for enabled flag");
   flag_clear_a: assert property ( // RULE18
      (wr_flags && !bus.wdata[0] && !vsel.lead) |=> !flags_q[0])
      else $error("flag not cleared by zero write");
   flag_keep_a: assert property ( // RULE18
      (wr_flags && flags_q[7] && bus.wdata[7]) |=> flags_q[7])
      else $error("flag lost on one write");
   read_slot_a: assert property ( // RULE20
      !bus.rd |=> rdata_q == 8'h00)
      else $error("read data outside its slot");
   status_read_a: assert property ( // RULE1
      (bus.rd && hit(bus.addr, ADDR_STATUS)) |=> rdata_q == $past(status_w))
      else $error("status read mismatch");
   ctrl_write_a: assert property ( // RULE20
      wr_ctrl0 |=> ctrl0_q == $past(bus.wdata))
      else $error("control write lost");
   auto_select_a: assert property ( // RULE10
      (sel == SEL_AUTO && cv_st.present && !v_st.present) |-> vsel == cv_st)
      else $error("auto select missed composite");
   vblank_pol_a: assert property ( // RULE13
      ##1 vblank_q == ($past(vsel.active) ^ $past(ctrl0_q[C0_VBLANK_POLARITY])))
      else $error("frame blanking polarity wrong");
   clamp_width_a: assert property ( // RULE16
      clamp_begin_s |=> cl_cnt_q == $past(clamp_len) && cl_state_q == CL_RUN)
      else $error("clamp width wrong");
   clamp_stop_a: assert property ( // RULE16
      clamp_end_s |=> cl_state_q == CL_IDLE ##1 clamp_q == !clamp_ctl_q[CL_POL])
      else $error("clamp pulse not ended");
   reserved_zero_a: assert property ( // RULE26
      (bus.rd && hit(bus.addr, ADDR_FRAME_HI)) |=> rdata_q[6:4] == 3'h0)
      else $error("reserved bits not zero");

   // Blanking and source selection
   hblank_pol_a: assert property ( // RULE12
      1'b1 |=> hblank_q == ($past(hblank_raw) ^ $past(ctrl0_q[C0_HBLANK_POLARITY])))
      else $error("line blanking polarity wrong");
   insert_off_a: assert property ( // RULE11
      (cv_time && ctrl0_q[C0_NOINS]) |=> hblank_q == $past(ctrl0_q[C0_HBLANK_POLARITY]))
      else $error("inserted pulse while suppressed");
   select_direct_a: assert property ( // RULE9
      (sel == SEL_OFF || sel == SEL_DIRECT) |-> vsel == v_st)
      else $error("direct source not used");
   select_comp_a: assert property ( // RULE9
      sel == SEL_COMPOSITE |-> vsel == cv_st)
      else $error("composite source not used");
   auto_direct_a: assert property ( // RULE10
      (sel == SEL_AUTO && !(cv_st.present && !v_st.present)) |-> vsel == v_st)
      else $error("auto select left direct input");
   cv_short_a: assert property ( // RULE2
      !h_st.active |=> !extracted_composite_vert_q)
      else $error("composite pulse without active line sync");

   // Count and enable registers as read back
   line_read_a: assert property ( // RULE7
      (bus.rd && hit(bus.addr, ADDR_LINE_HI)) |=>
         rdata_q == {$past(l_ovf), 1'b0, $past(line_pub_q[13:8])})
      else $error("line count high read wrong");
   frame_read_a: assert property ( // RULE8
      (bus.rd && hit(bus.addr, ADDR_FRAME_LO)) |=> rdata_q == $past(f_val[7:0]))
      else $error("frame count low read wrong");
   enable_read_a: assert property ( // RULE21
      (bus.rd && hit(bus.addr, ADDR_ENABLES)) |=> rdata_q == 8'h00)
      else $error("write-only enables read back");
   line_pub_a: assert property ( // RULE22
      line_pub |=> line_pub_q == $past(l_val))
      else $error("line count not published");

   // Event flags, the interrupt request and the clamp start
   sequence pres_clear_s;
      wr_flags && !bus.wdata[7] && h_st.present == prev_q[4];
   endsequence
   pres_clear_a: assert property ( // RULE18
      pres_clear_s |=> !flags_q[7])
      else $error("presence flag not cleared");
   pres_set_a: assert property ( // RULE21
      (h_st.present != prev_q[4]) |=> flags_q[7])
      else $error("line presence change not flagged");
   pulse_set_a: assert property ( // RULE17
      vsel.lead |=> flags_q[0])
      else $error("frame pulse not flagged");
   frame_rate_a: assert property ( // RULE24
      f_chg |=> flags_q[2])
      else $error("frame rate change not flagged");
   line_rate_a: assert property ( // RULE24
      line_ev |=> flags_q[3])
      else $error("line rate change not flagged");
   spare_flag_a: assert property ( // RULE21
      1'b1 |-> !flags_q[1])
      else $error("unused flag bit set");
   irq_release_a: assert property ( // RULE17
      !(|(flags_q & en_q)) |=> core_external_irq_1_n_q)
      else $error("interrupt held without enabled flag");
   clamp_idle_a: assert property ( // RULE14
      (cl_state_q == CL_IDLE && !clamp_start) |=> cl_state_q == CL_IDLE)
      else $error("clamp started without its edge");
endmodule // hvsp_regs

// file: verilog/hvsp_pkg.sv
// What this block does
// RULE1: Status bits: composite, polarities, presences, idle levels
// RULE2: Composite presence bit follows extracted vertical pulse
// RULE3: Line polarity bit: 1 positive, 0 negative
// RULE4: Frame polarity bit follows the selected vertical source
// RULE5: Presence bits read 1 while sync detected
// RULE6: Idle bits show static input level
// RULE7: Line count 14 bits split, overflow bit
// RULE8: Frame count 12 bits split, overflow bit
// RULE9: Source select picks composite, direct or off
// RULE10: Auto select uses composite when direct absent
// RULE11: Insert-suppress removes inserted blanking pulses
// RULE12: Control bit1 sets line blanking polarity
// RULE13: Control bit0 sets frame blanking polarity
// RULE14: Clamp starts on leading or trailing edge
// RULE15: Clamp polarity bit: 1 positive, 0 negative
// RULE16: Clamp width is field plus one steps
// RULE17: Enabled set flag drives interrupt low
// RULE18: Writing zero clears flag, one keeps it
// RULE19: Service software clears flags to release interrupt
// RULE20: Control 0 written where status is read
// RULE21: Flag and enable bit layout
// RULE22: Line count is ticks over 64 lines minus one
// RULE23: Frame count is ticks per frame
// RULE24: Rate flags set on change or overflow
// RULE25: Controls, enables and flags reset to zero
// RULE26: Reserved bits read as zero
package hvsp_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam logic [11:0] ADDR_STATUS = 12'hf40;
   localparam logic [11:0] ADDR_CTRL0 = 12'hf40;
   localparam logic [11:0] ADDR_LINE_HI = 12'hf41;
   localparam logic [11:0] ADDR_LINE_LO = 12'hf42;
   localparam logic [11:0] ADDR_FRAME_HI = 12'hf43;
   localparam logic [11:0] ADDR_CLAMP = 12'hf43;
   localparam logic [11:0] ADDR_FRAME_LO = 12'hf44;
   localparam logic [11:0] ADDR_FLAGS = 12'hf48;
   localparam logic [11:0] ADDR_ENABLES = 12'hf49;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] FLAG_MASK = 8'hfd;
   localparam logic [1:0] SEL_OFF = 2'h0;
   localparam logic [1:0] SEL_AUTO = 2'h1;
   localparam logic [1:0] SEL_DIRECT = 2'h2;
   localparam logic [1:0] SEL_COMPOSITE = 2'h3;
   localparam int C0_SEL_HI = 7;
   localparam int C0_SEL_LO = 6;
   localparam int C0_NOINS = 5;
   localparam int C0_HBLANK_POLARITY = 1;
   localparam int C0_VBLANK_POLARITY = 0;
   localparam int CL_EDGE = 6;
   localparam int CL_POL = 5;
   localparam int CL_W_HI = 4;
   localparam int CL_W_LO = 2;
   localparam int LINE_W = 14;
   localparam int FRAME_W = 12;
   localparam int unsigned LINE_TICK_HZ = 12800000 / 64;
   localparam int unsigned FRAME_TICK_HZ = 62500;
   localparam int unsigned LINE_TICK_CYC = CLK_HZ / LINE_TICK_HZ;
   localparam int unsigned FRAME_TICK_CYC = CLK_HZ / FRAME_TICK_HZ;
   localparam logic [5:0] LINE_AVG_LAST = 6'h3f;
   localparam int unsigned CLAMP_STEP_NS = 167;
   localparam int unsigned CLAMP_STEP_CYC = CLAMP_STEP_NS / CLK_PERIOD_NS;
   localparam int unsigned CV_MIN_NS = 8000;
   localparam int unsigned CV_MIN_CYC = (CV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LOSS_MS = 100;
   localparam int unsigned H_PRES_US = 100;
   localparam int unsigned V_PRES_MS = 25;
   localparam int unsigned LOSS_CYC_DEF = LOSS_MS * (CLK_HZ / 1000);
   localparam int unsigned H_PRES_CYC_DEF = H_PRES_US * (CLK_HZ / 1000000);
   localparam int unsigned V_PRES_CYC_DEF = V_PRES_MS * (CLK_HZ / 1000);
   localparam int TIMER_W = 23;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } hvsp_bus_t;
   typedef struct packed {
      logic present;
      logic polarity;
      logic idle;
      logic active;
      logic lead;
      logic trail;
   } hvsp_sync_t;
   typedef enum logic [1:0] {CL_IDLE = 2'b00, CL_RUN = 2'b01} hvsp_clamp_t;
endpackage

// file: verilog/hvsp_sync_mon.sv
`timescale 1ns/1ps
module hvsp_sync_mon
   import hvsp_pkg::*;
#(
   parameter int unsigned PRES_CYC = H_PRES_CYC_DEF,
   parameter int unsigned LOSS_CYC = LOSS_CYC_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sync_in,
   output hvsp_sync_t status
);
   logic in_q;
   logic pol_q;
   logic pres_q;
   logic [TIMER_W-1:0] hi_q, lo_q, gap_q;
   wire rise = sync_in & ~in_q;
   wire fall = ~sync_in & in_q;
   wire gap_sat = &gap_q;
   // High longer than low means negative polarity
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         in_q <= 1'b0;
         pol_q <= 1'b1;
         pres_q <= 1'b0;
         hi_q <= '0;
         lo_q <= '0;
         gap_q <= '0;
      end else begin
         in_q <= sync_in;
         hi_q <= rise ? '0 : ((in_q && !(&hi_q)) ? hi_q + 1'b1 : hi_q);
         lo_q <= fall ? '0 : ((!in_q && !(&lo_q)) ? lo_q + 1'b1 : lo_q);
         gap_q <= rise ? '0 : (gap_sat ? gap_q : gap_q + 1'b1);
         if (rise) pol_q <= !(hi_q > lo_q); // RULE3
         if (rise && gap_q < TIMER_W'(PRES_CYC)) pres_q <= 1'b1; // RULE5
         else if (gap_q >= TIMER_W'(LOSS_CYC)) pres_q <= 1'b0; // RULE5
      end
   end
   assign status.present = pres_q;
   assign status.polarity = pol_q;
   assign status.idle = in_q; // RULE6
   assign status.active = in_q ~^ pol_q;
   assign status.lead = pol_q ? rise : fall;
   assign status.trail = pol_q ? fall : rise;
endmodule // hvsp_sync_mon

// file: verilog/hvsp_period_ctr.sv
`timescale 1ns/1ps
module hvsp_period_ctr
   import hvsp_pkg::*;
#(
   parameter int W = LINE_W,
   parameter logic BIAS = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic mark,
   output logic [W-1:0] value_q,
   output logic ovf_q,
   output logic done_q,
   output logic chg_q
);
   logic [W-1:0] cnt_q;
   logic sat_q;
   wire [W-1:0] result = cnt_q - W'(BIAS);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
         sat_q <= 1'b0;
         value_q <= '0;
         ovf_q <= 1'b0;
         done_q <= 1'b0;
         chg_q <= 1'b0;
      end else begin
         done_q <= mark;
         chg_q <= (mark && result != value_q) || (tick && &cnt_q && !ovf_q); // RULE24
         if (mark) begin
            value_q <= result;
            ovf_q <= sat_q; // RULE7 RULE8
            cnt_q <= '0;
            sat_q <= 1'b0;
         end else if (tick) begin
            if (&cnt_q) begin
               sat_q <= 1'b1;
               ovf_q <= 1'b1;
            end else cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule // hvsp_period_ctr

// file: sim/hvsp_video_src.sv
`timescale 1ns/1ps
module hvsp_video_src #(
   parameter int H_PER = 300,
   parameter int H_W = 30,
   parameter int V_PER = 1200,
   parameter int V_W = 30
) (
   input wire logic clk,
   input wire logic h_run,
   input wire logic h_pos,
   input wire logic h_rest,
   input wire logic v_run,
   output logic hsync_in,
   output logic vsync_in
);
   int hc = 0;
   int vc = 0;
   always @(posedge clk) begin
      hc <= (hc == H_PER - 1) ? 0 : hc + 1;
      vc <= (vc == V_PER - 1) ? 0 : vc + 1;
      // A stopped line input rests at a static level so the idle bit can be seen
      hsync_in <= h_run ? ((hc < H_W) == h_pos) : h_rest;
      vsync_in <= v_run && (vc < V_W);
   end
endmodule // hvsp_video_src

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   import hvsp_pkg::*;
   localparam int H_PER = 300;
   localparam int V_PER = 1200;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   hvsp_bus_t bus = '0;
   logic h_run = 1'b0;
   logic h_pos = 1'b1;
   logic h_rest = 1'b0;
   logic v_run = 1'b0;
   logic hsync_in;
   logic vsync_in;
   logic [7:0] rdata_q;
   logic irq_n;
   logic hblank_q;
   logic vblank_q;
   logic clamp_q;
   logic cv_q;
   int error_cnt = 0;
   int cmp_count = 0;
   int seed = 32'h6c72c582;
   int n;
   logic [7:0] d;
   logic [7:0] hi;
   logic [31:0] r;

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   hvsp_regs #(.LOSS_CYC(2000), .H_PRES_CYC(500), .V_PRES_CYC(1500)) hvsp_regs_i (
      .clk(clk), .sys_rst(sys_rst), .bus(bus), .hsync_in(hsync_in), .vsync_in(vsync_in),
      .rdata_q(rdata_q), .core_external_irq_1_n_q(irq_n), .hblank_q(hblank_q),
      .vblank_q(vblank_q), .clamp_q(clamp_q), .extracted_composite_vert_q(cv_q));

   hvsp_video_src #(.H_PER(H_PER), .V_PER(V_PER)) hvsp_video_src_i (
      .clk(clk), .h_run(h_run), .h_pos(h_pos), .h_rest(h_rest), .v_run(v_run),
      .hsync_in(hsync_in), .vsync_in(vsync_in));

   function automatic int line_exp(input int per);
      return (64 * per) / LINE_TICK_CYC - 1;
   endfunction

   function automatic int frame_exp(input int per);
      return per / FRAME_TICK_CYC;
   endfunction

   task automatic complete_run();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [13:0] got, input int lo, input int hi_lim);
      cmp_count++;
      if ($isunknown(got) || got < lo || got > hi_lim) begin
         error_cnt++;
         $display("Error t=%0t got %h exp %h", $time, got, lo + 1);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= v;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] a, output logic [7:0] v);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      v = rdata_q;
   endtask

   task automatic wait_sig(ref logic s, input logic lvl, input int lim);
      n = 0;
      while (s !== lvl && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (s !== lvl) begin
         error_cnt++;
         $display("Error t=%0t got %h exp %h", $time, s, lvl);
         complete_run();
      end
   endtask

   task automatic settle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   initial begin
      settle(20);
      sys_rst <= 1'b0;
      settle(1);
      chk({7'h00, irq_n}, 8'h01);
      chk({7'h00, clamp_q}, 8'h01);
      rd_reg(ADDR_ENABLES, d);
      chk(d, 8'h00);
      rd_reg(12'hf4a, d);
      chk(d, 8'h00);
      wr_reg(ADDR_FLAGS, 8'h00);
      rd_reg(ADDR_FLAGS, d);
      chk(d, 8'h00);
      // Line presence interrupt: raise, hold with ones, release with a zero
      wr_reg(ADDR_ENABLES, 8'h80);
      h_run <= 1'b1;
      wait_sig(irq_n, 1'b0, 2000);
      rd_reg(ADDR_STATUS, d);
      chk(d & 8'hed, 8'h28);
      wr_reg(ADDR_FLAGS, 8'hff);
      rd_reg(ADDR_FLAGS, d);
      chk(d & 8'h80, 8'h80);
      wr_reg(ADDR_FLAGS, 8'h7f);
      settle(3);
      chk({7'h00, irq_n}, 8'h01);
      rd_reg(ADDR_FLAGS, d);
      chk(d & 8'h80, 8'h00);
      // Frame pulse interrupt
      v_run <= 1'b1;
      wr_reg(ADDR_ENABLES, 8'h01);
      wr_reg(ADDR_FLAGS, 8'h00);
      wait_sig(irq_n, 1'b0, V_PER + 100);
      wr_reg(ADDR_FLAGS, 8'hfe);
      settle(3);
      chk({7'h00, irq_n}, 8'h01);
      wr_reg(ADDR_ENABLES, 8'h00);
      // Period counts after enough lines and frames
      settle(45000);
      rd_reg(ADDR_LINE_HI, hi);
      rd_reg(ADDR_LINE_LO, d);
      chk(hi & 8'hc0, 8'h00);
      chk_rng({hi[5:0], d}, line_exp(H_PER) - 1, line_exp(H_PER) + 1);
      rd_reg(ADDR_FRAME_HI, hi);
      rd_reg(ADDR_FRAME_LO, d);
      chk(hi & 8'hf0, 8'h00);
      chk_rng({2'b00, hi[3:0], d}, frame_exp(V_PER) - 1, frame_exp(V_PER) + 1);
      rd_reg(ADDR_STATUS, d);
      chk(d & 8'h3c, 8'h3c);
      // Clamp edge, polarity and width, extremes first
      for (int i = 0; i < 5; i++) begin
         r = $random(seed);
         if (i < 2) r[2:0] = i ? 3'h0 : 3'h7;
         wr_reg(ADDR_CLAMP, {1'b0, r[3], r[4], r[2:0], 2'b00});
         settle(H_PER);
         wait_sig(clamp_q, ~r[4], H_PER);
         wait_sig(clamp_q, r[4], H_PER);
         chk({7'h00, hsync_in}, {7'h00, r[3]});
         n = 0;
         while (clamp_q === r[4] && n < 100) begin
            @(posedge clk);
            #1;
            n++;
         end
         chk(n[7:0], 8'((r[2:0] + 1) * CLAMP_STEP_CYC));
      end
      // Line polarity turned negative
      wr_reg(ADDR_FLAGS, 8'h00);
      h_pos <= 1'b0;
      settle(1500);
      rd_reg(ADDR_STATUS, d);
      chk(d & 8'h20, 8'h00);
      rd_reg(ADDR_FLAGS, d);
      chk(d & 8'h20, 8'h20);
      // Both inputs stopped: line high, frame low
      h_run <= 1'b0;
      h_rest <= 1'b1;
      v_run <= 1'b0;
      settle(2500);
      rd_reg(ADDR_STATUS, d);
      chk(d & 8'h8f, 8'h02);
      // Every source select with every blanking polarity
      for (int k = 0; k < 16; k++) begin
         r = $random(seed);
         wr_reg(ADDR_CTRL0, {k[3:2], r[5], 3'h0, k[1:0]});
         settle(4);
         chk({6'h00, hblank_q, vblank_q}, {6'h00, k[1], k[0]});
      end
      chk({7'h00, cv_q}, 8'h00);
      rd_reg(ADDR_STATUS, d);
      chk(d & 8'h8f, 8'h02);
      complete_run();
   end
endmodule // testbench
